// *** src/csoc_top.sv ***
`include "csoc_cfg.svh"

module csoc_top (
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port from the serial control port decoder
  input wire csoc_pkg::csoc_req_t req,
  output logic [`CSOC_DATA_W-1:0] rdata,
  output logic rvalid,
  // raw flags from the loop and frequency monitors
  input wire csoc_pkg::csoc_status_t monitor_flags,
  // decoded controls for clock_output_zero
  output csoc_pkg::csoc_drv_t drv,
  // stored control word, for the pad and the rest of the chip
  output csoc_pkg::csoc_ctrl_t ctrl
);
  import csoc_pkg::*;

  csoc_state_t state_reg;
  csoc_state_t state_next;
  csoc_status_t flags_sync;
  logic hit_status;
  logic hit_ctrl;

  // monitors run on their own clocks; bring every flag across first
  csoc_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .flags_async(monitor_flags),
    .flags_sync(flags_sync)
  );

  // address decode
  assign hit_status = (req.addr == `CSOC_OFS_STATUS);
  assign hit_ctrl = (req.addr == `CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL);

  // drive current lookup, in microamps
  function automatic logic [`CSOC_CUR_W-1:0] cur_ua(input logic [1:0] code);
    logic [`CSOC_CUR_W-1:0] ua;
    ua = `CSOC_CUR_UA_11;
    case (code)
      `CSOC_CUR_CODE_00: ua = `CSOC_CUR_UA_00;
      `CSOC_CUR_CODE_01: ua = `CSOC_CUR_UA_01;
      `CSOC_CUR_CODE_10: ua = `CSOC_CUR_UA_10;
      default: ua = `CSOC_CUR_UA_11;
    endcase
    return ua;
  endfunction

  // decode the control word into per-leg enables and inversions
  function automatic csoc_drv_t decode(input csoc_ctrl_t c);
    csoc_drv_t d;
    d = '0;
    d.current_code = c.current_code;
    d.current_ua = cur_ua(c.current_code);
    if (c.single_ended == `CSOC_FMT_DIFF) begin
      // differential: both legs always on, leg field kept but unused
      d.diff_mode = 1'b1;
      d.leg_a_enable = 1'b1;
      d.leg_b_enable = 1'b1;
      // upper polarity bit has no say here
      d.leg_a_invert = c.polarity[`CSOC_POL_LOW_BIT];
      d.leg_b_invert = ~c.polarity[`CSOC_POL_LOW_BIT];
    end else begin
      d.diff_mode = 1'b0;
      d.leg_a_enable = c.leg_enable[`CSOC_LEG_A_BIT];
      d.leg_b_enable = c.leg_enable[`CSOC_LEG_B_BIT];
      // low bit inverts A; B inverted when the two bits differ
      d.leg_a_invert = c.polarity[`CSOC_POL_LOW_BIT];
      d.leg_b_invert = c.polarity[`CSOC_POL_LOW_BIT]
                       ^ c.polarity[`CSOC_POL_HIGH_BIT];
    end
    return d;
  endfunction

  // decoded default setup as a constant, so the reset branch loads a plain value
  localparam csoc_drv_t drv_reset_val = decode(csoc_ctrl_t'(`CSOC_CTRL_RESET));

  // next-state logic: register writes, status capture, readback
  always_comb begin
    state_next = state_reg;
    if (ce) begin
      // flags from the monitors after the two u_sync stages, one capture per cycle
      // holdover bit is the loop state itself, not the holdover enable
      state_next.status = flags_sync;
      // only the control word accepts writes; status writes fall away
      if (req.wr && hit_ctrl) begin
        state_next.ctrl = csoc_ctrl_t'(req.wdata);
      end
      // readback; unmapped offsets return zero
      state_next.rvalid = req.rd;
      if (req.rd) begin
        if (hit_status) begin
          state_next.rdata = {`CSOC_STAT_PAD, state_reg.status};
        end else if (hit_ctrl) begin
          state_next.rdata = state_reg.ctrl;
        end else begin
          state_next.rdata = `CSOC_RDATA_RESET;
        end
      end
      // decoded pad controls follow the stored word in the same edge
      state_next.drv = decode(state_next.ctrl);
    end
  end

  // state register; reset puts the driver in its default differential setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.ctrl <= csoc_ctrl_t'(`CSOC_CTRL_RESET);
      state_reg.status <= `CSOC_STAT_RESET;
      state_reg.rdata <= `CSOC_RDATA_RESET;
      state_reg.rvalid <= 1'b0;
      state_reg.drv <= drv_reset_val;
    end else begin
      state_reg <= state_next;
    end
  end

  // every output leaves straight from the state register
  assign rdata = state_reg.rdata;
  assign rvalid = state_reg.rvalid;
  assign drv = state_reg.drv;
  assign ctrl = state_reg.ctrl;

endmodule

// *** src/csoc_cfg.svh ***
`ifndef CSOC_CFG_SVH
`define CSOC_CFG_SVH

// register port geometry
`define CSOC_ADDR_W 10
`define CSOC_DATA_W 8
`define CSOC_STAT_W 6

// register offsets
`define CSOC_OFS_STATUS 10'h01F
`define CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL 10'h0F0

// output control word reset value: differential, both legs, 3.5 mA code
`define CSOC_CTRL_RESET 8'h62
`define CSOC_STAT_RESET 6'h00
`define CSOC_RDATA_RESET 8'h00
`define CSOC_STAT_PAD 2'h0

// field codes
`define CSOC_FMT_DIFF 1'b0
`define CSOC_LEG_A_BIT 0
`define CSOC_LEG_B_BIT 1
`define CSOC_POL_LOW_BIT 0
`define CSOC_POL_HIGH_BIT 1

// drive current in microamps per code
`define CSOC_CUR_W 13
`define CSOC_CUR_CODE_00 2'h0
`define CSOC_CUR_CODE_01 2'h1
`define CSOC_CUR_CODE_10 2'h2
`define CSOC_CUR_UA_00 13'h06D6
`define CSOC_CUR_UA_01 13'h0DAC
`define CSOC_CUR_UA_10 13'h1482
`define CSOC_CUR_UA_11 13'h1B58

`endif

// *** src/csoc_pkg.sv ***
`include "csoc_cfg.svh"

package csoc_pkg;

  // request from the serial control port decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`CSOC_ADDR_W-1:0] addr;
    logic [`CSOC_DATA_W-1:0] wdata;
  } csoc_req_t;

  // live status flags, msb first as they sit in the status word
  typedef struct packed {
    logic holdover_active;
    logic secondary_selected;
    logic osc_above;
    logic secondary_above;
    logic primary_above;
    logic digital_lock;
  } csoc_status_t;

  // output zero driver control word
  typedef struct packed {
    logic single_ended;
    logic [1:0] leg_enable;
    logic [1:0] polarity;
    logic [1:0] current_code;
    logic power_down;
  } csoc_ctrl_t;

  // decoded driver controls toward the clock_output_zero pad
  typedef struct packed {
    logic diff_mode;
    logic leg_a_enable;
    logic leg_b_enable;
    logic leg_a_invert;
    logic leg_b_invert;
    logic [1:0] current_code;
    logic [`CSOC_CUR_W-1:0] current_ua;
  } csoc_drv_t;

  // synchroniser state
  typedef struct packed {
    csoc_status_t stage1;
    csoc_status_t stage2;
  } csoc_sync_state_t;

  // main block state
  typedef struct packed {
    csoc_ctrl_t ctrl;
    csoc_status_t status;
    logic [`CSOC_DATA_W-1:0] rdata;
    logic rvalid;
    csoc_drv_t drv;
  } csoc_state_t;

endpackage

// *** src/csoc_sync.sv ***
`include "csoc_cfg.svh"

module csoc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // flags from the monitors, asynchronous to clk
  input wire csoc_pkg::csoc_status_t flags_async,
  // flags after two stages
  output csoc_pkg::csoc_status_t flags_sync
);
  import csoc_pkg::*;

  csoc_sync_state_t state_reg;
  csoc_sync_state_t state_next;

  // stage1 feeds only stage2; nothing else looks at it
  always_comb begin
    state_next = state_reg;
    if (ce) begin
      state_next.stage1 = flags_async;
      state_next.stage2 = state_reg.stage1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= {`CSOC_STAT_RESET, `CSOC_STAT_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags_sync = state_reg.stage2;

endmodule

// *** bench/csoc_sva.sv ***
`include "csoc_cfg.svh"
module csoc_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire csoc_pkg::csoc_req_t req,
  input wire logic [`CSOC_DATA_W-1:0] rdata,
  input wire logic rvalid,
  // flags and driver side
  input wire csoc_pkg::csoc_status_t monitor_flags,
  input wire csoc_pkg::csoc_drv_t drv,
  input wire csoc_pkg::csoc_ctrl_t ctrl
);
  timeunit 1ns;
  timeprecision 1ns;
  import csoc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // flags must sit still long enough to cross both stages
  property p_stat;
    (ce && $stable(monitor_flags))[*6] ##0 (req.rd && req.addr == `CSOC_OFS_STATUS)
      |=> rdata == {2'h0, $past(monitor_flags)};
  endproperty
  property p_rv; ce |=> rvalid == $past(req.rd); endproperty
  property p_wr; ce && req.wr && req.addr == `CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL |=> ctrl == $past(req.wdata);
  endproperty
  property p_keep; !(ce && req.wr && req.addr == `CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL) |=> $stable(ctrl);
  endproperty
  property p_rdc; ce && req.rd && req.addr == `CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL |=> rdata == $past(ctrl);
  endproperty
  property p_diff;
    drv.diff_mode |-> drv.leg_a_enable && drv.leg_b_enable
      && drv.leg_a_invert == ctrl.polarity[0] && drv.leg_b_invert != ctrl.polarity[0];
  endproperty
  property p_se;
    !drv.diff_mode |-> {drv.leg_b_enable, drv.leg_a_enable} == ctrl.leg_enable
      && drv.leg_a_invert == ctrl.polarity[0] && drv.leg_b_invert == ^ctrl.polarity;
  endproperty
  // current steps in equal quarters of the top code
  property p_cur;
    drv.diff_mode != ctrl.single_ended && drv.current_code == ctrl.current_code
      && drv.current_ua == `CSOC_CUR_UA_00 * ({11'h000, ctrl.current_code} + 13'h0001);
  endproperty
  a_stat: assert property (p_stat) else $error("status readback");
  a_rv: assert property (p_rv) else $error("rvalid pulse");
  a_wr: assert property (p_wr) else $error("control write");
  a_keep: assert property (p_keep) else $error("control changed");
  a_rdc: assert property (p_rdc) else $error("control readback");
  a_diff: assert property (p_diff) else $error("differential legs");
  a_se: assert property (p_se) else $error("single-ended legs");
  a_cur: assert property (p_cur) else $error("format or current");
  c_wr: cover property (ce && req.wr && req.addr == `CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL);
  c_st: cover property (req.rd && req.addr == `CSOC_OFS_STATUS);
  c_se: cover property (!drv.diff_mode && drv.leg_a_enable && !drv.leg_b_enable);
endmodule

bind csoc_top csoc_sva u_sva (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req), .rdata(rdata),
  .rvalid(rvalid), .monitor_flags(monitor_flags), .drv(drv), .ctrl(ctrl));

// *** bench/test_clock_status_and_output_config.sv ***
`include "csoc_cfg.svh"
module test_clock_status_and_output_config;
  timeunit 1ns;
  timeprecision 1ns;
  import csoc_pkg::*;
  logic clk;
  logic rst_n;
  logic ce;
  csoc_req_t req;
  csoc_status_t monitor_flags;
  logic [7:0] rdata;
  logic rvalid;
  csoc_drv_t drv;
  csoc_ctrl_t ctrl;
  int miscompares;
  int samples_checked;
  logic [7:0] got;
  logic [7:0] w;

  csoc_top DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
    .monitor_flags(monitor_flags), .drv(drv), .ctrl(ctrl));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkd(input csoc_drv_t g, input csoc_drv_t e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one strobe cycle; an edge is let pass first so strobes never merge
  task automatic xfer(input logic wr, input logic rd, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req = '{wr, rd, a, d};
    @(posedge clk);
    #1;
    req = '0;
  endtask

  task automatic rd_reg(input logic [9:0] a, output logic [7:0] v);
    xfer(1'b0, 1'b1, a, 8'h00);
    // bounded wait; each look lands just after an edge, never on it
    for (int i = 0; i < 4 && rvalid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (rvalid !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
    v = rdata;
  endtask

  // driver decode worked out independently of the design
  function automatic csoc_drv_t dexp(input logic [7:0] c);
    csoc_drv_t e;
    e.diff_mode = ~c[7];
    e.leg_a_enable = ~c[7] | c[5];
    e.leg_b_enable = ~c[7] | c[6];
    e.leg_a_invert = c[3];
    e.leg_b_invert = c[7] ? c[3] ^ c[4] : ~c[3];
    e.current_code = c[2:1];
    e.current_ua = 13'h06D6 * ({11'h000, c[2:1]} + 13'h0001);
    return e;
  endfunction

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    monitor_flags = '0;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk8(ctrl, 8'h62);
    chkd(drv, dexp(8'h62));
    // walking one across every flag
    for (int i = 0; i < 6; i++) begin
      monitor_flags = csoc_status_t'(6'h01 << i);
      repeat (5) @(posedge clk);
      rd_reg(`CSOC_OFS_STATUS, got);
      chk8(got, 8'h01 << i);
    end
    xfer(1'b1, 1'b0, `CSOC_OFS_STATUS, 8'h00);
    rd_reg(`CSOC_OFS_STATUS, got);
    chk8(got, 8'h20);
    // every leg, polarity and current code in both formats
    for (int k = 0; k < 8; k++) begin
      w = {k[2], k[1:0], k[1:0], k[1:0], 1'b0};
      xfer(1'b1, 1'b0, `CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL, w);
      chkd(drv, dexp(w));
      rd_reg(`CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL, got);
      chk8(got, w);
    end
    // read beside a write sees the old word
    xfer(1'b1, 1'b1, `CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL, 8'h62);
    chk8(rdata, 8'hFE);
    // unmapped write, then a write while frozen, both dropped
    xfer(1'b1, 1'b0, 10'h0F1, 8'h00);
    ce = 1'b0;
    xfer(1'b1, 1'b0, `CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL, 8'h00);
    ce = 1'b1;
    rd_reg(`CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL, got);
    chk8(got, 8'h62);
    // mid-run reset: defaults return, status restarts from zero behind the stages
    xfer(1'b1, 1'b0, `CSOC_OFS_CLOCK_OUTPUT_ZERO_CTRL, 8'h9B);
    chkd(drv, dexp(8'h9B));
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk8(ctrl, 8'h62);
    chkd(drv, dexp(8'h62));
    rd_reg(`CSOC_OFS_STATUS, got);
    chk8(got, 8'h00);
    repeat (5) @(posedge clk);
    rd_reg(`CSOC_OFS_STATUS, got);
    chk8(got, 8'h20);
    give_verdict();
  end
endmodule
